// *** aws_status.sv ***
// Purpose: Position window output and coast input status flags with AXI4-Lite registers
// Assumes: Pins synchronous to aclk; position counter supplied by the motion logic
// Notes:   Flags are refreshed every enabled cycle
`timescale 1ns/1ps

// Operation
// [RL1] Window flag reads window output, zero at reset
// [RL2] Window on when position between both bounds
// [RL3] Window evaluated also while motor stands still
// [RL4] Window pin active level set by polarity
// [RL5] Coast flag reads coast input, zero at reset
// [RL6] Coast input compared against chosen polarity level
// [RL7] Coast flag zero while current disabled
// [RL8] Both flags refreshed every clock cycle (here only on cycles with clk_en high)
module aws_status
  import aws_pkg::*;
#(
  parameter int POS_W = 32
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    clk_en,
  input  wire logic signed [POS_W-1:0] position_counter,
  input  wire logic                    motor_moving,
  input  wire logic                    coast_request_input,
  output logic                         window_output_pin,
  output logic                         window_status_flag,
  output logic                         coast_input_status_flag,
  output logic                         motor_current_on,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  // ==========================================================================
  // Helpers
  // Byte-lane merge honouring the write strobes of every writable register
  function automatic logic [31:0] aws_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : aws_merge

  // Addresses that answer OKAY; anything else gets SLVERR and has no effect
  function automatic logic aws_known(input logic [7:0] a);
    return (a == AWS_OFF_STATUS) || (a == AWS_OFF_CTRL) || (a == AWS_OFF_BOUND1) ||
           (a == AWS_OFF_BOUND2) || (a == AWS_OFF_POSITION);
  endfunction : aws_known

  // The packed struct keeps its own field order; the register word layout
  // follows the package bit positions, so every conversion passes here.
  function automatic logic [31:0] aws_ctrl_word(input aws_ctrl_s c);
    logic [31:0] w;
    w                    = '0;
    w[AWS_BIT_WIN_POL]   = c.window_output_polarity;
    w[AWS_BIT_COAST_POL] = c.coast_input_polarity;
    w[AWS_BIT_CUR_EN]    = c.current_enable;
    return w;
  endfunction : aws_ctrl_word

  function automatic aws_ctrl_s aws_ctrl_fields(input logic [31:0] w);
    aws_ctrl_s c;
    c.window_output_polarity = w[AWS_BIT_WIN_POL];
    c.coast_input_polarity   = w[AWS_BIT_COAST_POL];
    c.current_enable         = w[AWS_BIT_CUR_EN];
    return c;
  endfunction : aws_ctrl_fields

  // Reset control value taken field by field, not in struct bit order
  localparam aws_ctrl_s CTRL_RST_FIELDS = aws_ctrl_fields({29'h0, AWS_CTRL_RST});

  // ==========================================================================
  // State
  aws_ctrl_s               ctrl_r,    ctrl_nxt;
  logic signed [POS_W-1:0] bound1_r,  bound1_nxt;
  logic signed [POS_W-1:0] bound2_r,  bound2_nxt;
  aws_stat_s               stat_r,    stat_nxt;
  logic                    win_pin_r, win_pin_nxt;

  // Write and read channel state
  logic                    aw_held_r, aw_held_nxt;
  logic [7:0]              aw_addr_r, aw_addr_nxt;
  logic                    w_held_r,  w_held_nxt;
  logic [31:0]             w_data_r,  w_data_nxt;
  logic [3:0]              w_strb_r,  w_strb_nxt;
  logic                    bvalid_r,  bvalid_nxt;
  logic [1:0]              bresp_r,   bresp_nxt;
  logic                    rvalid_r,  rvalid_nxt;
  logic [31:0]             rdata_r,   rdata_nxt;
  logic [1:0]              rresp_r,   rresp_nxt;

  // Combinational intermediates
  logic                    in_window;
  logic                    coast_active;
  logic                    do_write;
  logic [31:0]             rd_word;
  logic [31:0]             wr_merged;

  // ==========================================================================
  // Window and coast evaluation
  // Bounds may be given in either order, so compare against min and max.
  // motor_moving is deliberately unused in this block: the window holds at rest.
  // Both bounds are inclusive.
  always_comb begin
    if (bound1_r <= bound2_r) begin
      in_window = (position_counter >= bound1_r) &&
                  (position_counter <= bound2_r);                   // [RL2] [RL3]
    end else begin
      in_window = (position_counter >= bound2_r) &&
                  (position_counter <= bound1_r);                   // [RL2] [RL3]
    end
    coast_active = (coast_request_input == ctrl_r.coast_input_polarity); // [RL6]
  end

  always_comb begin
    stat_nxt.window_status_flag      = in_window;                   // [RL1] [RL8]
    // A disabled current masks the flag; it is not the real current state.
    stat_nxt.coast_input_status_flag = coast_active && ctrl_r.current_enable; // [RL5] [RL7] [RL8]
    win_pin_nxt = in_window ? ctrl_r.window_output_polarity
                            : ~ctrl_r.window_output_polarity;       // [RL4]
  end

  // ==========================================================================
  // AXI4-Lite write path
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    bound1_nxt  = bound1_r;
    bound2_nxt  = bound2_r;
    wr_merged   = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = aws_known(aw_addr_r) ? AWS_RESP_OKAY : AWS_RESP_SLVERR;
      unique case (aw_addr_r)
        AWS_OFF_CTRL: begin
          wr_merged = aws_merge(aws_ctrl_word(ctrl_r), w_data_r, w_strb_r);
          ctrl_nxt  = aws_ctrl_fields(wr_merged);
        end
        AWS_OFF_BOUND1: begin
          wr_merged  = aws_merge(32'(bound1_r), w_data_r, w_strb_r);
          bound1_nxt = POS_W'(wr_merged);
        end
        AWS_OFF_BOUND2: begin
          wr_merged  = aws_merge(32'(bound2_r), w_data_r, w_strb_r);
          bound2_nxt = POS_W'(wr_merged);
        end
        default: begin
          wr_merged = '0;
        end
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_awready = clk_en && !aw_held_r;
  assign s_axi_wready  = clk_en && !w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // ==========================================================================
  // AXI4-Lite read path
  always_comb begin
    rd_word = '0;
    unique case (s_axi_araddr)
      AWS_OFF_STATUS: begin
        rd_word[AWS_BIT_WINDOW_FLAG] = stat_r.window_status_flag;
        rd_word[AWS_BIT_COAST_FLAG]  = stat_r.coast_input_status_flag;
      end
      AWS_OFF_CTRL:     rd_word = aws_ctrl_word(ctrl_r);
      AWS_OFF_BOUND1:   rd_word = 32'(bound1_r);
      AWS_OFF_BOUND2:   rd_word = 32'(bound2_r);
      AWS_OFF_POSITION: rd_word = 32'(position_counter);
      default:          rd_word = '0;
    endcase
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = aws_known(s_axi_araddr) ? AWS_RESP_OKAY : AWS_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  assign s_axi_arready = clk_en && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==========================================================================
  // Configuration registers
  // Reset leaves current enabled and both polarities active low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RST_FIELDS;
      bound1_r <= POS_W'(AWS_BOUND_RST);
      bound2_r <= POS_W'(AWS_BOUND_RST);
    end else if (clk_en) begin
      ctrl_r   <= ctrl_nxt;
      bound1_r <= bound1_nxt;
      bound2_r <= bound2_nxt;
    end
  end

  // ==========================================================================
  // Status flags and window pin
  // Flags and pin move together, one enabled edge after their inputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r    <= '0;
      win_pin_r <= 1'b0;
    end else if (clk_en) begin
      stat_r    <= stat_nxt;
      win_pin_r <= win_pin_nxt;
    end
  end

  // ==========================================================================
  // Write channel registers
  // Address and data are parked separately so either may arrive first;
  // the response is built only once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= AWS_RESP_OKAY;
    end else if (clk_en) begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // ==========================================================================
  // Read channel registers
  // Read data is captured when the address is taken and then held.
  // Limitation: bvalid and rvalid are not masked by clk_en, so a master
  // must not finish a response handshake while the block is frozen.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= AWS_RESP_OKAY;
    end else if (clk_en) begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  assign window_output_pin       = win_pin_r;
  assign window_status_flag      = stat_r.window_status_flag;
  assign coast_input_status_flag = stat_r.coast_input_status_flag;
  assign motor_current_on        = ctrl_r.current_enable;

endmodule : aws_status

// *** aws_pkg.sv ***
// Purpose: Constants and types for the area window and coast input status block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Offsets are byte addresses
package aws_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] AWS_OFF_STATUS   = 8'h00;
  localparam logic [7:0] AWS_OFF_CTRL     = 8'h04;
  localparam logic [7:0] AWS_OFF_BOUND1   = 8'h08;
  localparam logic [7:0] AWS_OFF_BOUND2   = 8'h0C;
  localparam logic [7:0] AWS_OFF_POSITION = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int AWS_BIT_WINDOW_FLAG = 0;
  localparam int AWS_BIT_COAST_FLAG  = 1;
  localparam int AWS_BIT_WIN_POL     = 0;
  localparam int AWS_BIT_COAST_POL   = 1;
  localparam int AWS_BIT_CUR_EN      = 2;

  // ==========================================================================
  // Reset values
  localparam logic [2:0]  AWS_CTRL_RST  = 3'h4;
  localparam logic [31:0] AWS_BOUND_RST = 32'h0000_0000;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] AWS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AWS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic window_output_polarity;
    logic coast_input_polarity;
    logic current_enable;
  } aws_ctrl_s;

  typedef struct packed {
    logic window_status_flag;
    logic coast_input_status_flag;
  } aws_stat_s;

endpackage : aws_pkg

// *** aws_status_checker.sv ***
// Purpose: Port-level assertions for aws_status
// Assumes: aresetn synchronous, active low
// Notes:   Bound into every aws_status instance
`timescale 1ns/1ps
// ==========================================================================
// Checker
module aws_status_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        window_output_pin,
  input wire logic        window_status_flag,
  input wire logic        coast_input_status_flag,
  input wire logic        motor_current_on,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence

  a_win_rst: assert property (!$past(aresetn) |-> !window_status_flag)
    else $error("window flag set after reset");
  a_coast_rst: assert property (!$past(aresetn) |-> !coast_input_status_flag)
    else $error("coast flag set after reset");
  a_coast_off: assert property (!motor_current_on && !$past(motor_current_on)
    |-> !coast_input_status_flag) else $error("coast flag set with current off");
  a_flag_hold: assert property (!$past(clk_en) |-> $stable(window_status_flag)
    && $stable(coast_input_status_flag)) else $error("flag moved while frozen");
  a_pin_follow: assert property ($changed(window_status_flag) && $past(aresetn, 2)
    |-> $changed(window_output_pin)) else $error("window pin did not follow flag");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rd_clear: assert property (s_rd_taken ##1 s_rd_done |=> !s_axi_rvalid)
    else $error("read answer not cleared");
endmodule : aws_status_checker

bind aws_status aws_status_checker i_aws_status_checker (.*);

// *** aws_coast_model.sv ***
// Purpose: External controller driving the coast request pin
// Assumes: Level set by the bench, polarity mirrors the block setting
// Notes:   Starts inactive for active-low polarity
`timescale 1ns/1ps
// ==========================================================================
// Partner
module aws_coast_model (
  input wire logic aclk,
  input wire logic want_active,
  input wire logic active_high,
  output logic     coast_request_input
);
  initial coast_request_input = 1'b1;
  // Pin level meaning active depends on the chosen polarity
  always @(posedge aclk) coast_request_input <= active_high ? want_active : !want_active;
endmodule : aws_coast_model

// *** aws_status_tb.sv ***
// Purpose: Self-checking bench for aws_status
// Assumes: Bounds one and two set in reverse order
// Notes:   Random positions with boundary corners first
`timescale 1ns/1ps
// ==========================================================================
// Bench
module aws_status_tb;
  import aws_pkg::*;
  localparam logic signed [31:0] LO = 32'shFFFF_FC18;
  localparam logic signed [31:0] HI = 32'sh3E8;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, motor_moving = 1'b0;
  logic signed [31:0] position_counter = 32'sh5, p;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  logic window_output_pin, window_status_flag, coast_input_status_flag, motor_current_on;
  logic coast_request_input, want = 1'b0, cpol = 1'b0, wpol = 1'b0;
  logic [31:0] corner [6] = '{32'h3E8, 32'hFFFF_FC18, 32'h3E9, 32'hFFFF_FC17, 32'h0, 32'h5};
  int num_errors = 0, tests_run = 0;

  aws_status i_aws_status (.*);
  aws_coast_model i_aws_coast_model (.aclk, .want_active(want), .active_high(cpol),
    .coast_request_input);

  initial forever #5 aclk = ~aclk;

  function automatic logic in_win(input logic signed [31:0] x);
    return (x >= LO) && (x <= HI);
  endfunction : in_win

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      bs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hr);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic complete_run();
    $display("errors=%0d compares=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h29BB));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(AWS_OFF_STATUS);
    chk(d, 32'h0);
    rd(AWS_OFF_CTRL);
    chk(d, {29'h0, AWS_CTRL_RST});
    wr(AWS_OFF_STATUS, 32'h3);
    chk({30'h0, bs}, {30'h0, AWS_RESP_OKAY});
    rd(AWS_OFF_STATUS);
    chk(d, 32'h0);
    rd(8'h20);
    chk({30'h0, rs}, {30'h0, AWS_RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    chk({30'h0, bs}, {30'h0, AWS_RESP_SLVERR});
    s_axi_wstrb <= 4'hE;
    wr(AWS_OFF_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(AWS_OFF_CTRL);
    chk(d, {29'h0, AWS_CTRL_RST});
    wr(AWS_OFF_BOUND1, HI);
    wr(AWS_OFF_BOUND2, LO);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        wpol = 1'b1;
        wr(AWS_OFF_CTRL, 32'h5);
      end
      p = $urandom_range(32'hFA0);
      p = (i < 6) ? corner[i] : p - 32'sh7D0;
      position_counter <= p;
      motor_moving <= 1'($urandom);
      if (i == 10) begin
        clk_en <= 1'b0;
        repeat (3) @(posedge aclk);
        clk_en <= 1'b1;
      end
      repeat (2) @(posedge aclk);
      rd(AWS_OFF_STATUS);
      chk_bit(d[0], in_win(p));
      @(negedge aclk);
      chk_bit(window_status_flag, in_win(p));
      chk_bit(window_output_pin, in_win(p) ? wpol : !wpol);
      @(posedge aclk);
    end
    for (int k = 0; k < 8; k++) begin
      cpol <= k[1];
      want <= k[0];
      wr(AWS_OFF_CTRL, {29'h0, k[2], k[1], 1'b1});
      repeat (2) @(posedge aclk);
      rd(AWS_OFF_STATUS);
      chk_bit(d[1], k[0] && k[2]);
      @(negedge aclk);
      chk_bit(coast_input_status_flag, k[0] && k[2]);
      chk_bit(motor_current_on, k[2]);
      @(posedge aclk);
    end
    complete_run();
  end
endmodule : aws_status_tb
